// *** shared/isc_map.svh ***
// Register offsets, instruction codes, result codes and field positions.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
`ifndef ISC_MAP_SVH
`define ISC_MAP_SVH

`define OFF_INSTR        8'h00
`define OFF_INT_CODE     8'h04
`define OFF_FLAG         8'h08
`define OFF_MODE         8'h0c
`define OFF_RETRY        8'h10
`define OFF_SID_COUNT    8'h14

`define INS_START_SLEEP  8'h01
`define INS_REMOVE_SLEEP 8'h02
`define INS_START_BUSY   8'h03
`define INS_REMOVE_BUSY  8'h04
`define INS_BUS_RESET    8'h05
`define INS_SEND_FIRST   8'h30
`define INS_SEND_LAST    8'h38
`define INS_PING         8'h50
`define INS_CHAIN_START  8'h60
`define INS_CHAIN_STOP   8'h61
`define SPEED_MAX        8'h02

`define CODE_BUSY_ON     8'hf1
`define CODE_BUSY_OFF    8'hf2
`define CODE_ABORT_LEN   8'hf3
`define CODE_ABORT_STATE 8'hf4
`define CODE_CHAIN_STOP  8'hf5
`define CODE_RETRY_OUT   8'hf6
`define CODE_FATAL       8'hf7
`define CODE_PING_SID    8'he3

`define FLAG_BUSY_BIT    0
`define FLAG_CHAIN_BIT   1
`define FLAG_SLEEP_BIT   4
`define FLAG_PSLEEP_LSB  5
`define INT_PEND_BIT     8
`define MODE_SID_BIT     2

`define SID_LIMIT        8'h80
`define QUAD_BYTES       8'h04
`define RETRY_RESET      4'h3

`endif

// *** shared/isc_pkg.sv ***
// Types shared by the instruction, status and sleep control block.
// Assumes isc_map.svh is on the include path.
package isc_pkg;

	typedef struct packed {
		logic        busy;
		logic        sleep;
		logic        chain;
		logic [3:0]  retry_cnt;
		logic [3:0]  retry_limit;
		logic        sid_en;
		logic        ping_wait;
		logic [7:0]  sid_bytes;
		logic [31:0] sid_last;
		logic [7:0]  int_code;
		logic        int_pend;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        ack_busy;
		logic        tx_start;
		logic        bus_reset_req;
		logic        fifo_wr;
		logic [31:0] fifo_data;
		logic        fifo_flush;
		logic        chain_stop;
	} ctrl_s;

	typedef enum logic [1:0] {
		RES_NONE,
		RES_DONE,
		RES_CODE
	} res_e;

endpackage

// *** rtl/port_sleep.sv ***
// Automatic sleep of one serial bus port.
// Assumes connected and bias_seen are synchronous to mclk.
module port_sleep (
	input  wire logic mclk,         // Clock
	input  wire logic reset_n,      // Async reset, active low
	input  wire logic connected,    // Port has a live connection
	input  wire logic bias_seen,    // Bias detected on the port
	output logic      asleep        // Driver and comparator stopped
);

	typedef struct packed {
		logic asleep;
	} ps_s;

	ps_s st;
	ps_s st_next;

	always_comb begin
		st_next = st;
		if (bias_seen)
			st_next.asleep = 1'b0;
		else if (!connected)
			st_next.asleep = 1'b1;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= st_next;
	end

	assign asleep = st.asleep;

	bias_wake_a: assert property (@(posedge mclk) disable iff (!reset_n)
		bias_seen |=> !asleep)
		else $error("port stayed asleep with bias present");

	drop_sleep_a: assert property (@(posedge mclk) disable iff (!reset_n)
		!connected && !bias_seen |=> asleep)
		else $error("disconnected port not put to sleep");

endmodule // port_sleep

// *** rtl/instr_status_sleep_control.sv ***
// Instruction check, busy mode, chain stop, sleep and self-ID capture control.
// Assumes APB master on mclk (25 MHz); link side pulses are one mclk wide.
`include "isc_map.svh"

module instr_status_sleep_control
	import isc_pkg::*;
(
	input  wire logic        mclk,           // 25 MHz clock
	input  wire logic        reset_n,        // Async reset, active low
	input  wire logic        psel,           // APB select
	input  wire logic        penable,        // APB enable
	input  wire logic        pwrite,         // APB write
	input  wire logic [7:0]  paddr,          // APB byte address
	input  wire logic [31:0] pwdata,         // APB write data
	output logic             pready,         // APB ready
	output logic [31:0]      prdata,         // APB read data
	output logic             pslverr,        // APB error, unmapped address
	input  wire logic [12:0] tx_fifo_bytes,  // Bytes held for transmit
	input  wire logic [15:0] tx_data_length, // Header data-length field
	input  wire logic        async_rx_ok,    // Async packet received correctly
	input  wire logic        own_node_rx,    // Async packet to own node arriving
	input  wire logic        end_of_process_input, // End of process pin
	input  wire logic        chain_ack_busy, // Chain read got ack_busy
	input  wire logic        chain_done,     // Chain finished normally
	input  wire logic        hdr_crc_err,    // Header CRC error
	input  wire logic        ack_missing,    // Acknowledge missing
	input  wire logic        bus_reset_seen, // Bus reset detected
	input  wire logic [1:0]  port_connect,   // New connection event per port
	input  wire logic [1:0]  port_connected, // Connection level per port
	input  wire logic [1:0]  port_bias,      // Bias detected per port
	input  wire logic        sid_phase,      // Self-ID stage of bus reset
	input  wire logic        sid_valid,      // Self-ID quadlet strobe
	input  wire logic        sid_inverse,    // Quadlet is the inverted check
	input  wire logic [31:0] sid_quad,       // Self-ID quadlet
	output logic             ack_busy_reply, // Send ack_busy for this packet
	output logic             tx_start,       // Start packet transmission
	output logic             bus_reset_req,  // Start a bus reset
	output logic             chain_stop,     // Chain transfer terminated
	output logic             rx_fifo_wr,     // Write to async receive FIFO
	output logic [31:0]      rx_fifo_data,   // Data for async receive FIFO
	output logic             rx_fifo_flush,  // Discard receive FIFO contents
	output logic             link_halt,      // Link and physical logic halted
	output logic             host_clk_half,  // Host interface at half rate
	output logic             port_power_off, // Ports electrically disconnected
	output logic             pll_stop,       // PLL stopped but wake circuit
	output logic [1:0]       port_asleep     // Per-port automatic sleep
);

	ctrl_s st;
	ctrl_s st_next;
	res_e  res;
	logic [7:0] res_code;
	logic [7:0] op;
	logic [7:0] operand;
	logic       access;
	logic       wr_done;
	logic       rd_done;
	logic       instr_wr;
	logic       mapped;
	logic       link_on;
	logic       send_op;
	logic       len_short;
	logic [31:0] flag_word;

	assign access    = psel && penable && !st.pready;
	assign wr_done   = psel && penable && pwrite && st.pready && !st.pslverr;
	assign rd_done   = psel && penable && !pwrite && st.pready;
	assign instr_wr  = wr_done && (paddr == `OFF_INSTR);
	assign op        = pwdata[7:0];
	assign operand   = pwdata[15:8];
	assign link_on   = !st.sleep;
	assign send_op   = (op >= `INS_SEND_FIRST) && (op <= `INS_SEND_LAST);
	assign len_short = {3'b000, tx_fifo_bytes} < tx_data_length;
	assign mapped    = (paddr == `OFF_INSTR) || (paddr == `OFF_INT_CODE) ||
		(paddr == `OFF_FLAG) || (paddr == `OFF_MODE) ||
		(paddr == `OFF_RETRY) || (paddr == `OFF_SID_COUNT);

	always_comb begin
		flag_word = '0;
		flag_word[`FLAG_BUSY_BIT] = st.busy;
		flag_word[`FLAG_CHAIN_BIT] = st.chain;
		flag_word[`FLAG_SLEEP_BIT] = st.sleep;
		flag_word[`FLAG_PSLEEP_LSB +: 2] = port_asleep;
	end

	// Instruction decode; result code issued one edge after the write
	always_comb begin
		res = RES_NONE;
		res_code = '0;
		if (instr_wr) begin
			res = RES_DONE;
			if (st.sleep) begin
				if (op != `INS_REMOVE_SLEEP || operand != 8'h00) begin
					res = RES_CODE;
					res_code = `CODE_ABORT_STATE;
				end
			end else if (send_op) begin
				if (operand > `SPEED_MAX) begin
					res = RES_CODE;
					res_code = `CODE_ABORT_STATE;
				end else if (len_short) begin
					res = RES_CODE;
					res_code = `CODE_ABORT_LEN;
				end
			end else if (operand != 8'h00) begin
				res = RES_CODE;
				res_code = `CODE_ABORT_STATE;
			end else begin
				unique case (op)
					`INS_START_SLEEP, `INS_BUS_RESET, `INS_PING,
					`INS_CHAIN_START: res = RES_DONE;
					`INS_START_BUSY: begin
						res = RES_CODE;
						res_code = `CODE_BUSY_ON;
					end
					`INS_REMOVE_BUSY: begin
						res = RES_CODE;
						res_code = `CODE_BUSY_OFF;
					end
					`INS_CHAIN_STOP: begin
						res = RES_CODE;
						res_code = st.chain ? `CODE_CHAIN_STOP : `CODE_ABORT_STATE;
					end
					default: begin
						res = RES_CODE;
						res_code = `CODE_ABORT_STATE;
					end
				endcase
			end
		end
	end

	always_comb begin
		st_next = st;
		st_next.ack_busy = 1'b0;
		st_next.tx_start = 1'b0;
		st_next.bus_reset_req = 1'b0;
		st_next.fifo_wr = 1'b0;
		st_next.fifo_flush = 1'b0;
		st_next.chain_stop = 1'b0;
		st_next.pready = 1'b0;
		st_next.pslverr = 1'b0;

		// APB: one wait state, then ready with registered data
		if (access) begin
			st_next.pready = 1'b1;
			st_next.pslverr = !mapped;
			st_next.prdata = '0;
			if (!pwrite) begin
				if (paddr == `OFF_INT_CODE)
					st_next.prdata = {23'h000000, st.int_pend, st.int_code};
				else if (paddr == `OFF_FLAG)
					st_next.prdata = flag_word;
				else if (paddr == `OFF_MODE)
					st_next.prdata[`MODE_SID_BIT] = st.sid_en;
				else if (paddr == `OFF_RETRY)
					st_next.prdata = {28'h0000000, st.retry_limit};
				else if (paddr == `OFF_SID_COUNT)
					st_next.prdata = {24'h000000, st.sid_bytes};
			end
		end
		if (rd_done && paddr == `OFF_INT_CODE)
			st_next.int_pend = 1'b0;
		if (wr_done && paddr == `OFF_MODE)
			st_next.sid_en = pwdata[`MODE_SID_BIT];
		if (wr_done && paddr == `OFF_RETRY)
			st_next.retry_limit = pwdata[3:0];

		// Link events; all of them are ignored in forced sleep
		if (link_on) begin
			if (own_node_rx && st.busy)
				st_next.ack_busy = 1'b1;
			if (async_rx_ok && !st.busy) begin
				st_next.busy = 1'b1;
				st_next.int_code = `CODE_BUSY_ON;
				st_next.int_pend = 1'b1;
			end
			if (|port_connect)
				st_next.bus_reset_req = 1'b1;
			if (sid_valid) begin
				if (!sid_inverse) begin
					st_next.sid_last = sid_quad;
					if ((st.ping_wait || (sid_phase && st.sid_en)) &&
						st.sid_bytes <= `SID_LIMIT - `QUAD_BYTES) begin
						st_next.fifo_wr = 1'b1;
						st_next.fifo_data = sid_quad;
						st_next.sid_bytes = st.sid_bytes + `QUAD_BYTES;
					end
				end else if (st.ping_wait && sid_quad == ~st.sid_last) begin
					st_next.ping_wait = 1'b0;
					st_next.int_code = `CODE_PING_SID;
					st_next.int_pend = 1'b1;
				end
			end
			if (st.chain && chain_done)
				st_next.chain = 1'b0;
			if (st.chain && chain_ack_busy) begin
				if (st.retry_cnt == st.retry_limit) begin
					st_next.chain = 1'b0;
					st_next.chain_stop = 1'b1;
					st_next.int_code = `CODE_RETRY_OUT;
					st_next.int_pend = 1'b1;
				end else
					st_next.retry_cnt = st.retry_cnt + 4'h1;
			end
			if (st.chain && end_of_process_input) begin
				st_next.chain = 1'b0;
				st_next.chain_stop = 1'b1;
				st_next.int_code = `CODE_CHAIN_STOP;
				st_next.int_pend = 1'b1;
			end
			if (st.chain && (hdr_crc_err || ack_missing || bus_reset_seen)) begin
				st_next.chain = 1'b0;
				st_next.chain_stop = 1'b1;
				st_next.int_code = `CODE_FATAL;
				st_next.int_pend = 1'b1;
			end
			if (bus_reset_seen) begin
				st_next.fifo_flush = 1'b1;
				st_next.fifo_wr = 1'b0;
				st_next.sid_bytes = '0;
				st_next.ping_wait = 1'b0;
			end
		end

		// Instruction effects take priority over link events
		if (instr_wr && res != RES_CODE) begin
			if (st.sleep)
				st_next.sleep = 1'b0;
			else if (send_op)
				st_next.tx_start = 1'b1;
			else if (op == `INS_START_SLEEP)
				st_next.sleep = 1'b1;
			else if (op == `INS_BUS_RESET)
				st_next.bus_reset_req = 1'b1;
			else if (op == `INS_PING) begin
				st_next.ping_wait = 1'b1;
				st_next.tx_start = 1'b1;
			end else if (op == `INS_CHAIN_START) begin
				st_next.chain = 1'b1;
				st_next.retry_cnt = '0;
				st_next.tx_start = 1'b1;
			end
		end
		if (res == RES_CODE) begin
			st_next.int_code = res_code;
			st_next.int_pend = 1'b1;
			if (res_code == `CODE_BUSY_ON)
				st_next.busy = 1'b1;
			if (res_code == `CODE_BUSY_OFF)
				st_next.busy = 1'b0;
			if (res_code == `CODE_CHAIN_STOP) begin
				st_next.chain = 1'b0;
				st_next.chain_stop = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.retry_limit <= `RETRY_RESET;
		end else
			st <= st_next;
	end

	genvar gi;
	for (gi = 0; gi < 2; gi++) begin : g_port
		port_sleep u_port_sleep (
			.mclk      (mclk),
			.reset_n   (reset_n),
			.connected (port_connected[gi]),
			.bias_seen (port_bias[gi]),
			.asleep    (port_asleep[gi])
		);
	end

	assign pready         = st.pready;
	assign prdata         = st.prdata;
	assign pslverr        = st.pslverr;
	assign ack_busy_reply = st.ack_busy;
	assign tx_start       = st.tx_start;
	assign bus_reset_req  = st.bus_reset_req;
	assign chain_stop     = st.chain_stop;
	assign rx_fifo_wr     = st.fifo_wr;
	assign rx_fifo_data   = st.fifo_data;
	assign rx_fifo_flush  = st.fifo_flush;
	assign link_halt      = st.sleep;
	assign host_clk_half  = st.sleep;
	assign port_power_off = st.sleep;
	assign pll_stop       = st.sleep;

	start_busy_a: assert property (@(posedge mclk) disable iff (!reset_n)
		instr_wr && !st.sleep && pwdata[15:0] == {8'h00, `INS_START_BUSY}
		|=> st.busy && st.int_pend && st.int_code == `CODE_BUSY_ON)
		else $error("start busy did not report busy entry");

	busy_ack_a: assert property (@(posedge mclk) disable iff (!reset_n)
		own_node_rx && st.busy && !st.sleep |=> ack_busy_reply)
		else $error("busy mode did not answer with ack_busy");

	busy_exit_a: assert property (@(posedge mclk) disable iff (!reset_n)
		instr_wr && !st.sleep && pwdata[15:0] == {8'h00, `INS_REMOVE_BUSY}
		|=> !st.busy && st.int_code == `CODE_BUSY_OFF)
		else $error("remove busy did not leave busy mode");

	short_data_a: assert property (@(posedge mclk) disable iff (!reset_n)
		instr_wr && !st.sleep && send_op && operand <= `SPEED_MAX && len_short
		|=> st.int_code == `CODE_ABORT_LEN && !tx_start)
		else $error("short transmit data not aborted");

	sleep_abort_a: assert property (@(posedge mclk) disable iff (!reset_n)
		instr_wr && st.sleep && op != `INS_REMOVE_SLEEP
		|=> st.sleep && st.int_code == `CODE_ABORT_STATE)
		else $error("instruction in sleep not aborted");

	proc_end_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st.chain && end_of_process_input && !st.sleep && !instr_wr
		|=> !st.chain && chain_stop)
		else $error("end of process did not stop chain");

	retry_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st.chain && chain_ack_busy && st.retry_cnt == st.retry_limit && !st.sleep && !instr_wr
		|=> !st.chain && chain_stop)
		else $error("retry limit did not end chain");

	fatal_stop_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st.chain && hdr_crc_err && !st.sleep && !instr_wr
		|=> st.int_code == `CODE_FATAL)
		else $error("header error did not report fatal");

	connect_reset_a: assert property (@(posedge mclk) disable iff (!reset_n)
		|port_connect && !st.sleep |=> bus_reset_req)
		else $error("connection did not start bus reset");

	sleep_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
		instr_wr && st.sleep && pwdata[15:0] == {8'h00, `INS_REMOVE_SLEEP}
		|=> !link_halt && !flag_word[`FLAG_SLEEP_BIT])
		else $error("remove sleep did not wake");

	sid_limit_a: assert property (@(posedge mclk) disable iff (!reset_n)
		st.sid_bytes <= `SID_LIMIT)
		else $error("self-ID store passed its limit");

	reset_flush_a: assert property (@(posedge mclk) disable iff (!reset_n)
		bus_reset_seen && !st.sleep |=> rx_fifo_flush && !rx_fifo_wr && st.sid_bytes == 8'h00)
		else $error("bus reset did not flush self-ID data");

endmodule // instr_status_sleep_control

// *** testbench/isc_host.sv ***
// APB master standing in for the host processor.
// Assumes the bench watchdog ends a transfer whose pready never comes.
module isc_host (
	input  wire logic        mclk,    // Clock
	output logic             psel,    // Select
	output logic             penable, // Enable
	output logic             pwrite,  // Direction
	output logic [7:0]       paddr,   // Byte address
	output logic [31:0]      pwdata,  // Write data
	input  wire logic        pready,  // Ready
	input  wire logic [31:0] prdata,  // Read data
	input  wire logic        pslverr  // Error
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// Called just after a rising edge; returns one edge after the release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
		@(posedge mclk);
	endtask
endmodule // isc_host

// *** testbench/instr_status_sleep_control_tb.sv ***
// Self-checking bench for the instruction, status and sleep control block.
// Assumes isc_map.svh on the include path and isc_host as the APB master.
`include "isc_map.svh"
module instr_status_sleep_control_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, seed, q, rx_fifo_data, sid_quad;
	logic [12:0] tx_fifo_bytes;
	logic [15:0] tx_data_length;
	logic async_rx_ok, own_node_rx, end_of_process_input, chain_ack_busy, chain_done;
	logic hdr_crc_err, ack_missing, bus_reset_seen, sid_phase, sid_valid, sid_inverse;
	logic ack_busy_reply, tx_start, bus_reset_req, chain_stop, rx_fifo_wr, rx_fifo_flush;
	logic link_halt, host_clk_half, port_power_off, pll_stop;
	logic [1:0] port_connect, port_connected, port_bias, port_asleep;
	int bad_count, comparisons, pend, code, sid_bytes, tx_cnt, exp_tx, len, rst_cnt;
	logic [31:0] exp_q[$];
	logic [7:0] ev; // Link event pulses, one bit per event input
	localparam int rx_ix = 0, own_ix = 1, end_ix = 2, retry_ix = 3;
	localparam int done_ix = 4, crc_ix = 5, miss_ix = 6, reset_ix = 7;

	assign {bus_reset_seen, ack_missing, hdr_crc_err, chain_done, chain_ack_busy,
		end_of_process_input, own_node_rx, async_rx_ok} = ev;

	isc_host host (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	instr_status_sleep_control uut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.tx_fifo_bytes(tx_fifo_bytes), .tx_data_length(tx_data_length),
		.async_rx_ok(async_rx_ok), .own_node_rx(own_node_rx),
		.end_of_process_input(end_of_process_input), .chain_ack_busy(chain_ack_busy),
		.chain_done(chain_done), .hdr_crc_err(hdr_crc_err), .ack_missing(ack_missing),
		.bus_reset_seen(bus_reset_seen), .port_connect(port_connect),
		.port_connected(port_connected), .port_bias(port_bias), .sid_phase(sid_phase),
		.sid_valid(sid_valid), .sid_inverse(sid_inverse), .sid_quad(sid_quad),
		.ack_busy_reply(ack_busy_reply), .tx_start(tx_start), .bus_reset_req(bus_reset_req),
		.chain_stop(chain_stop), .rx_fifo_wr(rx_fifo_wr), .rx_fifo_data(rx_fifo_data),
		.rx_fifo_flush(rx_fifo_flush), .link_halt(link_halt), .host_clk_half(host_clk_half),
		.port_power_off(port_power_off), .pll_stop(pll_stop), .port_asleep(port_asleep));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rdreg(input logic [7:0] a, input logic [31:0] exp);
		host.xfer(1'b0, a, 32'h0, rd, err);
		cmp(rd, exp);
	endtask

	// Reads the result code; a negative argument means no new code is due
	task automatic rdcode(input int c);
		if (c >= 0) begin
			code = c;
			pend = 1;
		end
		host.xfer(1'b0, `OFF_INT_CODE, 32'h0, rd, err);
		cmp(rd, 32'(pend * 256 + code));
		pend = 0;
	endtask

	task automatic instr(input logic [31:0] d, input int c);
		host.xfer(1'b1, `OFF_INSTR, d, rd, err);
		rdcode(c);
	endtask

	// One-cycle event in, then the pulse output checked in the cycle it stands
	task automatic pulse(input int k, const ref logic o, input logic e);
		ev[k] <= 1'b1;
		@(posedge mclk);
		ev[k] <= 1'b0;
		#1;
		cmp({31'h0, o}, {31'h0, e});
		@(posedge mclk);
	endtask

	task automatic chain_end(input int k, input int c);
		instr(32'h60, -1);
		exp_tx++;
		pulse(k, chain_stop, 1'b1);
		rdcode(c);
	endtask

	task automatic sid(input logic inv, input logic [31:0] v, input logic cap);
		sid_valid <= 1'b1;
		sid_inverse <= inv;
		sid_quad <= v;
		@(posedge mclk);
		sid_valid <= 1'b0;
		sid_quad <= ~v;
		if (!inv && cap && sid_bytes < 128) begin
			exp_q.push_back(v);
			sid_bytes += 4;
		end
		@(posedge mclk);
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		if (tx_start === 1'b1) tx_cnt++;
		if (bus_reset_req === 1'b1) rst_cnt++;
		if (rx_fifo_wr === 1'b1) cmp(rx_fifo_data, exp_q.size() ? exp_q.pop_front() : ~rx_fifo_data);
	end

	initial begin
		#400000;
		bad_count++;
		stop_test();
	end

	initial begin
		ev = '0;
		{sid_phase, sid_valid, sid_inverse} = '0;
		{tx_fifo_bytes, tx_data_length, sid_quad, port_connect} = '0;
		port_connected = 2'b11;
		port_bias = 2'b11;
		seed = 32'h769a;
		reset_n = 1'b0;
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rdcode(-1);
		rdreg(`OFF_RETRY, {28'h0, `RETRY_RESET});
		rdreg(`OFF_FLAG, 32'h0);
		rdreg(8'h18, 32'h0);
		cmp({31'h0, err}, 32'h1);
		// Busy mode by instruction and by packet
		instr(32'h03, 'hf1);
		rdreg(`OFF_FLAG, 32'h1);
		pulse(own_ix, ack_busy_reply, 1'b1);
		instr(32'h04, 'hf2);
		pulse(own_ix, ack_busy_reply, 1'b0);
		pulse(rx_ix, tx_start, 1'b0);
		rdcode('hf1);
		instr(32'h04, 'hf2);
		// Send instructions: short data, full data, every speed code
		for (int op = 'h30; op <= 'h38; op++) begin
			len = int'(rnd() % 200) + 1;
			tx_data_length <= 16'(len);
			tx_fifo_bytes <= 13'(len - 1);
			instr(32'(op), 'hf3);
			tx_fifo_bytes <= 13'(len + op % 2);
			instr(32'(op + 256 * (op % 3)), -1);
			exp_tx++;
			instr(32'(op + 256 * 3), 'hf4);
		end
		instr(32'hff, 'hf4);
		instr(32'h0103, 'hf4);
		instr(32'h02, 'hf4);
		instr(32'h61, 'hf4);
		// Chain retry limit, suspend and fatal ends
		host.xfer(1'b1, `OFF_RETRY, 32'h1, rd, err);
		rdreg(`OFF_RETRY, 32'h1);
		instr(32'h60, -1);
		exp_tx++;
		rdreg(`OFF_FLAG, 32'h2);
		pulse(retry_ix, chain_stop, 1'b0);
		pulse(retry_ix, chain_stop, 1'b1);
		rdcode('hf6);
		instr(32'h60, -1);
		exp_tx++;
		instr(32'h61, 'hf5);
		chain_end(end_ix, 'hf5);
		chain_end(crc_ix, 'hf7);
		chain_end(miss_ix, 'hf7);
		chain_end(reset_ix, 'hf7);
		// Normal chain completion ends the chain with no stop and no code
		instr(32'h60, -1);
		exp_tx++;
		pulse(done_ix, chain_stop, 1'b0);
		rdreg(`OFF_FLAG, 32'h0);
		rdcode(-1);
		// Ports: connection starts a bus reset, idle port sleeps and wakes
		port_connect <= 2'b10;
		@(posedge mclk);
		port_connect <= 2'b00;
		#1;
		cmp({31'h0, bus_reset_req}, 32'h1);
		@(posedge mclk);
		port_connected <= 2'b10;
		port_bias <= 2'b10;
		repeat (2) @(posedge mclk);
		#1;
		cmp({30'h0, port_asleep}, 32'h1);
		@(posedge mclk);
		port_bias <= 2'b11;
		@(posedge mclk);
		#1;
		cmp({30'h0, port_asleep}, 32'h0);
		@(posedge mclk);
		port_connected <= 2'b11;
		// Forced sleep
		instr(32'h01, -1);
		rdreg(`OFF_FLAG, 32'h10);
		cmp({28'h0, link_halt, host_clk_half, port_power_off, pll_stop}, 32'hf);
		pulse(rx_ix, tx_start, 1'b0);
		instr(32'h03, 'hf4);
		instr(32'h02, -1);
		rdreg(`OFF_FLAG, 32'h0);
		cmp({28'h0, link_halt, host_clk_half, port_power_off, pll_stop}, 32'h0);
		// Self-ID capture, limit, flush, ping reply
		host.xfer(1'b1, `OFF_MODE, 32'h4, rd, err);
		rdreg(`OFF_MODE, 32'h4);
		sid_phase <= 1'b1;
		for (int i = 0; i < 34; i++) begin
			q = rnd();
			sid(1'b0, q, 1'b1);
			if (i < 3) sid(1'b1, ~q, 1'b1);
		end
		rdreg(`OFF_SID_COUNT, 32'h80);
		sid_phase <= 1'b0;
		pulse(reset_ix, rx_fifo_flush, 1'b1);
		sid_bytes = 0;
		rdreg(`OFF_SID_COUNT, 32'h0);
		host.xfer(1'b1, `OFF_MODE, 32'h0, rd, err);
		sid_phase <= 1'b1;
		sid(1'b0, rnd(), 1'b0);
		sid_phase <= 1'b0;
		instr(32'h50, -1);
		exp_tx++;
		q = rnd();
		sid(1'b0, q, 1'b1);
		sid(1'b1, ~q, 1'b0);
		rdcode('he3);
		cmp(32'(exp_q.size()), 32'h0);
		cmp(32'(tx_cnt), 32'(exp_tx));
		// Bus reset instruction; one request from it, one from the port connection
		instr(32'h05, -1);
		cmp(32'(rst_cnt), 32'h2);
		stop_test();
	end
endmodule // instr_status_sleep_control_tb
